// File: inc/haptic_map.svh
// Register offsets, field positions, reset values and timing constants
`ifndef HAPTIC_MAP_SVH
`define HAPTIC_MAP_SVH
`define REG_STATUS    8'h00
`define REG_MODE      8'h01
`define REG_GO        8'h02
`define REG_LIB       8'h03
`define REG_RTP       8'h04
`define REG_LEVEL     8'h05
`define REG_RES_HI    8'h06
`define REG_RES_LO    8'h07
`define REG_TRIG      8'h08
`define MODE_RST      8'h40
`define MODE_STBY     6
`define MODE_SEL_HI   1
`define MODE_SEL_LO   0
`define PM_RTP        2'h0
`define PM_SEQ        2'h1
`define PM_CAL        2'h3
`define TRIG_RST      8'h01
`define TRIG_EDGE     2'h0
`define TRIG_LEVEL    2'h1
`define TRIG_FN_HI    1
`define TRIG_OL       2
`define LIB_RST       8'h00
`define RTP_RST       8'h00
`define LEVEL_RST     8'h80
`define LEVEL_MAX     8'hFF
`define GO_BIT        0
`define ST_UNDERVOLTAGE_LOCKOUT       0
`define ST_PLAY       1
`define ST_LOCK       2
`define ST_CALD       3
`define ST_READY      4
`define ST_STBY       5
`define DEV_ADDR      7'h2C
`define BYTE_BITS     4'h8
`define MCLK_MHZ      250
`define PWRUP_WAIT_US 1000
`define STARTUP_US    500
`define CAL_STEP_LAST 8'h3F
`endif

// File: inc/haptic_pkg.sv
// Shared types of the haptic control block
`default_nettype none
package haptic_pkg;
  typedef logic [7:0] reg_byte_t;
  typedef enum logic [1:0] {CTL_IDLE, CTL_PLAY, CTL_CAL} ctl_state_t;
  typedef enum logic [2:0] {
    I_IDLE, I_DEV, I_REG, I_WR, I_SACK, I_RD, I_MACK
  } i2c_state_t;
endpackage
`default_nettype wire

// File: design/i2c_target.sv
// Oversampled two-wire target with a register pointer
`timescale 1ns/1ps
`default_nettype none
`include "haptic_map.svh"
module i2c_target (
  input  wire logic                mclk,
  input  wire logic                rstn,
  input  wire logic                scl_pin,
  input  wire logic                sda_pin,
  input  wire logic                accept,
  input  wire haptic_pkg::reg_byte_t rd_data,
  output logic                     wr_stb,
  output haptic_pkg::reg_byte_t    wr_addr,
  output haptic_pkg::reg_byte_t    wr_data,
  output haptic_pkg::reg_byte_t    rd_addr,
  output logic                     sda_oe_n
);
  import haptic_pkg::*;
  logic [1:0] s1_r;
  logic [1:0] s2_r;
  logic [1:0] s3_r;
  i2c_state_t st_r;
  i2c_state_t ack_nxt_r;
  reg_byte_t  sh_r;
  reg_byte_t  tx_r;
  reg_byte_t  ptr_r;
  logic [3:0] cnt_r;
  logic       nack_r;
  wire scl_rise = s2_r[1] & ~s3_r[1];
  wire scl_fall = ~s2_r[1] & s3_r[1];
  wire start    = s2_r[1] & s3_r[1] & s3_r[0] & ~s2_r[0];
  wire stop     = s2_r[1] & s3_r[1] & ~s3_r[0] & s2_r[0];
  wire byte_end = (cnt_r == `BYTE_BITS);

  assign rd_addr = ptr_r;

  // Pins come from another clock; stages two and three feed logic
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      s1_r <= 2'h3;
      s2_r <= 2'h3;
      s3_r <= 2'h3;
    end else begin
      s1_r <= {scl_pin, sda_pin};
      s2_r <= s1_r;
      s3_r <= s2_r;
    end
  end

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      st_r      <= I_IDLE;
      ack_nxt_r <= I_IDLE;
      sh_r      <= 8'h00;
      tx_r      <= 8'h00;
      ptr_r     <= 8'h00;
      cnt_r     <= 4'h0;
      nack_r    <= 1'b1;
      sda_oe_n  <= 1'b1;
      wr_stb    <= 1'b0;
      wr_addr   <= 8'h00;
      wr_data   <= 8'h00;
    end else begin
      wr_stb <= 1'b0;
      if (start) begin
        st_r     <= I_DEV;
        cnt_r    <= 4'h0;
        sda_oe_n <= 1'b1;
      end else if (stop) begin
        st_r     <= I_IDLE;
        sda_oe_n <= 1'b1;
      end else if (scl_rise) begin
        if (st_r == I_DEV || st_r == I_REG || st_r == I_WR) begin
          sh_r  <= {sh_r[6:0], s2_r[0]};
          cnt_r <= cnt_r + 4'h1;
        end else if (st_r == I_MACK) begin
          nack_r <= s2_r[0];
        end
      end else if (scl_fall) begin
        case (st_r)
          I_DEV: if (byte_end) begin
            if (sh_r[7:1] == `DEV_ADDR && accept) begin
              sda_oe_n  <= 1'b0;
              ack_nxt_r <= sh_r[0] ? I_RD : I_REG;
              st_r      <= I_SACK;
            end else begin
              st_r <= I_IDLE;
            end
          end
          I_REG: if (byte_end) begin
            ptr_r     <= sh_r;
            sda_oe_n  <= 1'b0;
            ack_nxt_r <= I_WR;
            st_r      <= I_SACK;
          end
          I_WR: if (byte_end) begin
            wr_stb    <= 1'b1;
            wr_addr   <= ptr_r;
            wr_data   <= sh_r;
            ptr_r     <= ptr_r + 8'h01;
            sda_oe_n  <= 1'b0;
            ack_nxt_r <= I_WR;
            st_r      <= I_SACK;
          end
          I_SACK: begin
            if (ack_nxt_r == I_RD) begin
              tx_r     <= rd_data;
              sda_oe_n <= rd_data[7];
              cnt_r    <= 4'h1;
            end else begin
              sda_oe_n <= 1'b1;
              cnt_r    <= 4'h0;
            end
            st_r <= ack_nxt_r;
          end
          I_RD: begin
            if (byte_end) begin
              sda_oe_n <= 1'b1;
              ptr_r    <= ptr_r + 8'h01;
              st_r     <= I_MACK;
            end else begin
              tx_r     <= {tx_r[6:0], 1'b0};
              sda_oe_n <= tx_r[6];
              cnt_r    <= cnt_r + 4'h1;
            end
          end
          I_MACK: begin
            // Reads stream on while the controller acknowledges
            if (nack_r) begin
              st_r <= I_IDLE;
            end else begin
              tx_r     <= rd_data;
              sda_oe_n <= rd_data[7];
              cnt_r    <= 4'h1;
              st_r     <= I_RD;
            end
          end
          default: st_r <= I_IDLE;
        endcase
      end
    end
  end
endmodule // i2c_target
`default_nettype wire

// File: design/haptic_ctrl.sv
// Bring-up, trigger, calibration and resonance control of the haptic driver
// Function
// - Writing 0x00 to the mode register at 0x01 leaves standby.
// - Reset gives closed loop, realtime playback and level triggering.
// - Resonance locks in half a cycle and then tracks every half cycle.
// - Calibration sets drive level only and never touches resonance.
// - An edge or level on the trigger pin starts playback without bus.
// - Default settings allow operation from the pins alone.
// - A supply slower than the 500 us startup flags lockout, no play.
`timescale 1ns/1ps
`default_nettype none
`include "haptic_map.svh"
module haptic_ctrl #(
  parameter int PWRUP_CYC   = `PWRUP_WAIT_US * `MCLK_MHZ,
  parameter int STARTUP_CYC = `STARTUP_US * `MCLK_MHZ
) (
  input  wire logic              mclk,
  input  wire logic              rstn,
  input  wire logic              scl,
  input  wire logic              sda_i,
  output logic                   sda_o,
  output logic                   sda_oe_n,
  input  wire logic              shutdown_release_n,
  input  wire logic              trigger_or_irq_pin,
  input  wire logic              supply_good,
  input  wire logic              bemf_zero_cross,
  input  wire logic              bemf_level_ok,
  output logic                   drive_en,
  output haptic_pkg::reg_byte_t  drive_amp,
  output logic                   drive_open_loop
);
  import haptic_pkg::*;
  logic [3:0]  sync1_r;
  logic [3:0]  sync2_r;
  logic        trig_q_r;
  logic        zc_q_r;
  logic [17:0] pwr_cnt_r;
  logic        ready_r;
  logic        undervoltage_lockout_r;
  reg_byte_t   mode_r;
  reg_byte_t   lib_r;
  reg_byte_t   rtp_r;
  reg_byte_t   level_r;
  reg_byte_t   trig_r;
  ctl_state_t  state_r;
  ctl_state_t  state_nxt;
  reg_byte_t   cal_lvl_r;
  reg_byte_t   cal_cnt_r;
  logic        cal_done_r;
  logic [15:0] res_cnt_r;
  logic [15:0] res_per_r;
  logic        res_seen_r;
  logic        locked_r;
  logic        trig_start;
  logic        trig_stop;
  logic        play_end;
  logic        cal_end;
  logic        trig_wake;
  reg_byte_t   status;
  logic        wr_stb;
  reg_byte_t   wr_addr;
  reg_byte_t   wr_data;
  reg_byte_t   rd_addr;
  reg_byte_t   rd_val;
  wire shut_s  = sync2_r[0];
  wire trig_s  = sync2_r[1];
  wire sup_s   = sync2_r[2];
  wire zc_s    = sync2_r[3];
  wire zc_edge = zc_s ^ zc_q_r;
  wire [1:0] mode_sel = mode_r[`MODE_SEL_HI:`MODE_SEL_LO];
  wire [1:0] trig_fn  = trig_r[`TRIG_FN_HI:0];
  wire go_wr = wr_stb && wr_addr == `REG_GO && wr_data[`GO_BIT];
  wire cal_tick = cal_cnt_r == `CAL_STEP_LAST;
  logic lvl_s1_r;
  logic lvl_s_r;

  function automatic reg_byte_t reg_read(input reg_byte_t a);
    if (a == `REG_STATUS)      reg_read = status;
    else if (a == `REG_MODE)   reg_read = mode_r;
    else if (a == `REG_LIB)    reg_read = lib_r;
    else if (a == `REG_RTP)    reg_read = rtp_r;
    else if (a == `REG_LEVEL)  reg_read = level_r;
    else if (a == `REG_RES_HI) reg_read = res_per_r[15:8];
    else if (a == `REG_RES_LO) reg_read = res_per_r[7:0];
    else if (a == `REG_TRIG)   reg_read = trig_r;
    else                       reg_read = 8'h00;
  endfunction

  // Read mux as a process, so it follows every register it reads
  always_comb rd_val = reg_read(rd_addr);

  i2c_target u_bus (
    .mclk     (mclk),
    .rstn     (rstn),
    .scl_pin  (scl),
    .sda_pin  (sda_i),
    .accept   (ready_r && shut_s),
    .rd_data  (rd_val),
    .wr_stb   (wr_stb),
    .wr_addr  (wr_addr),
    .wr_data  (wr_data),
    .rd_addr  (rd_addr),
    .sda_oe_n (sda_oe_n)
  );

  // Pin inputs: first stage is read by the second only
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      sync1_r  <= 4'h0;
      sync2_r  <= 4'h0;
      lvl_s1_r <= 1'b0;
      lvl_s_r  <= 1'b0;
      trig_q_r <= 1'b0;
      zc_q_r   <= 1'b0;
    end else begin
      sync1_r <= {bemf_zero_cross, supply_good, trigger_or_irq_pin,
                  shutdown_release_n};
      sync2_r  <= sync1_r;
      lvl_s1_r <= bemf_level_ok;
      lvl_s_r  <= lvl_s1_r;
      trig_q_r <= trig_s;
      zc_q_r   <= zc_s;
    end
  end

  always_comb begin
    status = 8'h00;
    status[`ST_UNDERVOLTAGE_LOCKOUT]  = undervoltage_lockout_r;
    status[`ST_PLAY]  = (state_r == CTL_PLAY);
    status[`ST_LOCK]  = locked_r;
    status[`ST_CALD]  = cal_done_r;
    status[`ST_READY] = ready_r;
    status[`ST_STBY]  = mode_r[`MODE_STBY];
  end

  // Power timer runs from power-on, not from the shutdown pin
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      pwr_cnt_r <= 18'h0_0000;
      ready_r   <= 1'b0;
      undervoltage_lockout_r    <= 1'b0;
    end else begin
      if (pwr_cnt_r != 18'(PWRUP_CYC))
        pwr_cnt_r <= pwr_cnt_r + 18'h0_0001;
      if (pwr_cnt_r == 18'(PWRUP_CYC))
        ready_r <= 1'b1;
      if (wr_stb && wr_addr == `REG_STATUS && wr_data[`ST_UNDERVOLTAGE_LOCKOUT])
        undervoltage_lockout_r <= 1'b0;
      if (pwr_cnt_r == 18'(STARTUP_CYC) && !sup_s)
        undervoltage_lockout_r <= 1'b1;
    end
  end

  always_comb begin
    trig_start = 1'b0;
    trig_stop  = 1'b0;
    if (trig_fn == `TRIG_LEVEL) begin
      trig_start = trig_s;
      // Only a falling pin ends play; a grounded pin leaves bus play alone
      trig_stop  = trig_q_r && !trig_s;
    end else if (trig_fn == `TRIG_EDGE) begin
      trig_start = trig_s && !trig_q_r;
      trig_stop  = trig_s && !trig_q_r;
    end
  end

  always_comb begin
    state_nxt = state_r;
    play_end  = 1'b0;
    cal_end   = 1'b0;
    trig_wake = 1'b0;
    case (state_r)
      CTL_IDLE: begin
        if (!undervoltage_lockout_r) begin
          if (trig_start) begin
            state_nxt = CTL_PLAY;
            trig_wake = 1'b1;
          end else if (go_wr && !mode_r[`MODE_STBY]) begin
            state_nxt = (mode_sel == `PM_CAL) ? CTL_CAL : CTL_PLAY;
          end
        end
      end
      CTL_PLAY: begin
        if (go_wr || trig_stop || undervoltage_lockout_r) begin
          state_nxt = CTL_IDLE;
          play_end  = 1'b1;
        end
      end
      CTL_CAL: begin
        if (cal_tick && (lvl_s_r || cal_lvl_r == `LEVEL_MAX)) begin
          state_nxt = CTL_IDLE;
          cal_end   = 1'b1;
        end
      end
      default: state_nxt = CTL_IDLE;
    endcase
  end

  // Shutdown pin low acts as a reset of the control state
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      state_r    <= CTL_IDLE;
      cal_lvl_r  <= 8'h00;
      cal_cnt_r  <= 8'h00;
      cal_done_r <= 1'b0;
    end else if (!shut_s) begin
      state_r    <= CTL_IDLE;
      cal_lvl_r  <= 8'h00;
      cal_cnt_r  <= 8'h00;
      cal_done_r <= 1'b0;
    end else begin
      state_r <= state_nxt;
      if (state_r == CTL_CAL) begin
        cal_cnt_r <= cal_tick ? 8'h00 : cal_cnt_r + 8'h01;
        if (cal_tick && !cal_end)
          cal_lvl_r <= cal_lvl_r + 8'h01;
      end else begin
        cal_cnt_r <= 8'h00;
        cal_lvl_r <= 8'h00;
      end
      if (cal_end)
        cal_done_r <= 1'b1;
    end
  end

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      mode_r  <= `MODE_RST;
      lib_r   <= `LIB_RST;
      rtp_r   <= `RTP_RST;
      level_r <= `LEVEL_RST;
      trig_r  <= `TRIG_RST;
    end else if (!shut_s) begin
      mode_r  <= `MODE_RST;
      lib_r   <= `LIB_RST;
      rtp_r   <= `RTP_RST;
      level_r <= `LEVEL_RST;
      trig_r  <= `TRIG_RST;
    end else begin
      if (wr_stb) begin
        if (wr_addr == `REG_MODE)       mode_r  <= wr_data;
        else if (wr_addr == `REG_LIB)   lib_r   <= wr_data;
        else if (wr_addr == `REG_RTP)   rtp_r   <= wr_data;
        else if (wr_addr == `REG_LEVEL) level_r <= wr_data;
        else if (wr_addr == `REG_TRIG)  trig_r  <= wr_data;
      end
      // Finished playback drops back into standby to save power
      if (play_end || cal_end)
        mode_r[`MODE_STBY] <= 1'b1;
      if (trig_wake)
        mode_r[`MODE_STBY] <= 1'b0;
      if (cal_end)
        level_r <= cal_lvl_r;
    end
  end

  // Half-cycle timer; calibration freezes it so results survive
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      res_cnt_r  <= 16'h0000;
      res_per_r  <= 16'h0000;
      res_seen_r <= 1'b0;
      locked_r   <= 1'b0;
    end else if (state_r == CTL_IDLE) begin
      res_cnt_r  <= 16'h0000;
      res_seen_r <= 1'b0;
      locked_r   <= 1'b0;
    end else if (state_r == CTL_PLAY && !trig_r[`TRIG_OL]) begin
      if (zc_edge) begin
        res_cnt_r  <= 16'h0001;
        res_seen_r <= 1'b1;
        if (res_seen_r) begin
          res_per_r <= res_cnt_r;
          locked_r  <= 1'b1;
        end
      end else if (res_cnt_r != 16'hFFFF) begin
        res_cnt_r <= res_cnt_r + 16'h0001;
      end
    end
  end

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      drive_en        <= 1'b0;
      drive_amp       <= 8'h00;
      drive_open_loop <= 1'b0;
      sda_o           <= 1'b0;
    end else begin
      drive_en        <= (state_nxt != CTL_IDLE) && shut_s;
      drive_amp       <= (state_nxt == CTL_CAL) ? cal_lvl_r :
                         (mode_sel == `PM_RTP) ? rtp_r : level_r;
      drive_open_loop <= trig_r[`TRIG_OL];
      sda_o           <= 1'b0;
    end
  end

  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rstn);

  AST_EARLY_REFUSED: assert property (
    !ready_r |-> !wr_stb) else $error("Write taken before power wait");
  AST_WAKE: assert property (
    wr_stb && wr_addr == `REG_MODE && wr_data == 8'h00 && shut_s
    && state_r == CTL_IDLE |=> !mode_r[`MODE_STBY] && !status[`ST_STBY])
    else $error("Mode write did not leave standby");
  AST_DEFAULTS: assert property (
    !shut_s |=> mode_r == `MODE_RST && trig_r == `TRIG_RST
    && state_r == CTL_IDLE) else $error("Shutdown defaults wrong");
  AST_HALF_LOCK: assert property (
    state_r == CTL_PLAY && !trig_r[`TRIG_OL] && zc_edge && res_seen_r
    |=> locked_r && res_per_r == $past(res_cnt_r))
    else $error("Resonance not locked at half cycle");
  AST_CAL_KEEPS_RES: assert property (
    state_r == CTL_CAL |=> $stable(res_per_r))
    else $error("Calibration changed resonance");
  AST_TRIG_FIRE: assert property (
    state_r == CTL_IDLE && trig_start && !undervoltage_lockout_r && shut_s
    |=> state_r == CTL_PLAY && drive_en) else $error("Trigger ignored");
  AST_LEVEL_STOP: assert property (
    state_r == CTL_PLAY && trig_fn == `TRIG_LEVEL && !trig_s && trig_q_r
    && shut_s
    |=> state_r == CTL_IDLE ##1 !drive_en)
    else $error("Level trigger did not stop");
  AST_PINS_ONLY: assert property (
    trig_r == `TRIG_RST && $rose(trig_s) && state_r == CTL_IDLE
    && !undervoltage_lockout_r && shut_s |=> drive_en)
    else $error("Default pins-only start failed");
  AST_UNDERVOLTAGE_LOCKOUT_SET: assert property (
    pwr_cnt_r == 18'(STARTUP_CYC) && !sup_s |=> undervoltage_lockout_r)
    else $error("Slow ramp not flagged");
  AST_UNDERVOLTAGE_LOCKOUT_REFUSE: assert property (
    undervoltage_lockout_r && state_r != CTL_CAL |=> state_r != CTL_PLAY)
    else $error("Played under lockout");
endmodule // haptic_ctrl
`default_nettype wire

// File: test/i2c_host_model.sv
// Two-wire bus controller model acting as the application processor
`timescale 1ns/1ps
`default_nettype none
`include "haptic_map.svh"
module i2c_host_model (
  output logic      scl,
  output logic      sda_oe_n,
  input  wire logic sda_line
);
  // Clock idles driven high; data idles released, held high by the pull-up
  initial begin
    scl = 1'b1;
    sda_oe_n = 1'b1;
  end
  // Quarter of the 125 ns link period
  task automatic q();
    #31.25;
  endtask
  // Small offset keeps bus edges off the mclk edges
  task automatic start_c();
    #0.1;
    sda_oe_n = 1'b1;
    q();
    scl = 1'b1;
    q();
    sda_oe_n = 1'b0;
    q();
    scl = 1'b0;
    q();
  endtask
  task automatic stop_c();
    sda_oe_n = 1'b0;
    q();
    scl = 1'b1;
    q();
    sda_oe_n = 1'b1;
    q();
  endtask
  // Eight bits MSB first, then the line is released for the answer
  task automatic xbyte(input logic [7:0] d, output logic [7:0] r,
                       output logic ack);
    logic b;
    r   = 8'h00;
    ack = 1'b0;
    for (int i = 0; i < 9; i++) begin
      sda_oe_n = (i == 8) ? 1'b1 : d[7-i];
      q();
      scl = 1'b1;
      q();
      b = sda_line;
      // Ninth bit is the answer, kept apart from the data byte
      if (i == 8)
        ack = ~b;
      else
        r[7-i] = b;
      q();
      scl = 1'b0;
      q();
    end
  endtask
  task automatic write_reg(input logic [7:0] a, input logic [7:0] d,
                           output logic ok);
    logic [7:0] r;
    logic       k0, k1, k2;
    start_c();
    xbyte({`DEV_ADDR, 1'b0}, r, k0);
    xbyte(a, r, k1);
    xbyte(d, r, k2);
    stop_c();
    ok = k0 & k1 & k2;
  endtask
  // Read ends with a released ninth bit, so the target stops sending
  task automatic read_reg(input logic [7:0] a, output logic [7:0] d,
                          output logic ok);
    logic [7:0] r;
    logic       k0, k1, k2;
    start_c();
    xbyte({`DEV_ADDR, 1'b0}, r, k0);
    xbyte(a, r, k1);
    start_c();
    xbyte({`DEV_ADDR, 1'b1}, r, k2);
    xbyte(8'hFF, d, k0);
    stop_c();
    ok = k1 & k2;
  endtask
endmodule // i2c_host_model
`default_nettype wire

// File: test/haptic_ctrl_bench.sv
// Self-checking bench of the haptic control block
`timescale 1ns/1ps
`default_nettype none
`include "haptic_map.svh"
module haptic_ctrl_bench;
  import haptic_pkg::*;
  // Shortened power and startup waits keep the run brief
  localparam int PWRUP   = 2000;
  localparam int STARTUP = 1000;
  logic      mclk, rstn, scl, sda_line, sda_o, dut_oe_n, host_oe_n;
  logic      shut_n, trig, sup_ok, zc, lvl_ok, drive_en, drive_ol;
  reg_byte_t drive_amp;
  int        miscompares = 0;
  int        comparisons = 0;
  always #2 mclk = ~mclk;
  // Open-drain data line with pull-up
  assign sda_line = (dut_oe_n === 1'b0 || host_oe_n === 1'b0) ? 1'b0 : 1'b1;
  haptic_ctrl #(.PWRUP_CYC(PWRUP), .STARTUP_CYC(STARTUP)) u_haptic_ctrl (
    .mclk(mclk), .rstn(rstn), .scl(scl), .sda_i(sda_line), .sda_o(sda_o),
    .sda_oe_n(dut_oe_n), .shutdown_release_n(shut_n),
    .trigger_or_irq_pin(trig), .supply_good(sup_ok),
    .bemf_zero_cross(zc), .bemf_level_ok(lvl_ok), .drive_en(drive_en),
    .drive_amp(drive_amp), .drive_open_loop(drive_ol));
  i2c_host_model u_i2c_host_model (
    .scl(scl), .sda_oe_n(host_oe_n), .sda_line(sda_line));
  task automatic complete_run();
    $display("comparisons %0d miscompares %0d", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  task automatic chk_bit(input logic g, input logic e, input string w);
    comparisons++;
    if (g !== e) begin
      miscompares++;
      $display("[ERR] %0t %s got %b exp %b", $time, w, g, e);
    end
  endtask
  task automatic chk_byte(input reg_byte_t g, input reg_byte_t e,
                          input string w);
    comparisons++;
    if (g !== e) begin
      miscompares++;
      $display("[ERR] %0t %s got %h exp %h", $time, w, g, e);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(negedge mclk);
  endtask
  task automatic wr(input reg_byte_t a, input reg_byte_t d, input logic ea);
    logic ok;
    u_i2c_host_model.write_reg(a, d, ok);
    @(negedge mclk);
    chk_bit(ok, ea, "write ack");
  endtask
  task automatic rd(input reg_byte_t a, input reg_byte_t e);
    logic      ok;
    reg_byte_t d;
    u_i2c_host_model.read_reg(a, d, ok);
    @(negedge mclk);
    chk_bit(ok, 1'b1, "read ack");
    chk_byte(d, e, "read data");
  endtask
  // Bounded wait for the drive enable to reach a level
  task automatic wait_en(input logic v, input int n);
    for (int i = 0; i < n && drive_en !== v; i++) @(negedge mclk);
    chk_bit(drive_en, v, "drive enable");
  endtask
  task automatic toggle(input int n, input int gap);
    repeat (n) begin
      tick(gap);
      zc = ~zc;
    end
  endtask
  task automatic t_reset();
    tick(2);
    chk_bit(drive_en, 1'b0, "reset enable");
    chk_bit(drive_ol, 1'b0, "reset loop");
    chk_bit(dut_oe_n, 1'b1, "reset sda");
    chk_byte(drive_amp, 8'h00, "reset amp");
    tick(2);
    rstn = 1'b1;
  endtask
  task automatic t_pins();
    wr(`REG_LIB, 8'h01, 1'b0);
    trig = 1'b1;
    wait_en(1'b1, 12);
    tick(20);
    chk_bit(drive_en, 1'b1, "level hold");
    trig = 1'b0;
    wait_en(1'b0, 12);
    tick(PWRUP);
  endtask
  task automatic t_defaults();
    rd(`REG_MODE, `MODE_RST);
    rd(`REG_TRIG, `TRIG_RST);
    rd(`REG_LIB, 8'h00);
    rd(`REG_RTP, 8'h00);
    rd(`REG_LEVEL, `LEVEL_RST);
    rd(8'h09, 8'h00);
    chk_bit(drive_ol, 1'b0, "closed loop");
    chk_bit(sda_o, 1'b0, "sda level");
  endtask
  task automatic t_shutdown();
    wr(`REG_LIB, 8'h01, 1'b1);
    rd(`REG_LIB, 8'h01);
    shut_n = 1'b0;
    tick(4);
    wr(`REG_LIB, 8'h02, 1'b0);
    shut_n = 1'b1;
    tick(4);
    rd(`REG_LIB, 8'h00);
  endtask
  task automatic t_mode_go();
    wr(`REG_RTP, 8'h5A, 1'b1);
    wr(`REG_GO, 8'h01, 1'b1);
    tick(20);
    chk_bit(drive_en, 1'b0, "standby go");
    rd(`REG_STATUS, 8'h30);
    wr(`REG_MODE, 8'h00, 1'b1);
    rd(`REG_STATUS, 8'h10);
    wr(`REG_GO, 8'h01, 1'b1);
    wait_en(1'b1, 12);
    chk_byte(drive_amp, 8'h5A, "rtp amp");
    wr(`REG_GO, 8'h01, 1'b1);
    wait_en(1'b0, 12);
    rd(`REG_MODE, 8'h40);
  endtask
  task automatic t_resonance();
    wr(`REG_MODE, 8'h00, 1'b1);
    wr(`REG_GO, 8'h01, 1'b1);
    wait_en(1'b1, 12);
    toggle(3, 40);
    rd(`REG_RES_HI, 8'h00);
    rd(`REG_RES_LO, 8'h28);
    rd(`REG_STATUS, 8'h16);
    toggle(3, 50);
    rd(`REG_RES_LO, 8'h32);
    wr(`REG_GO, 8'h01, 1'b1);
    wait_en(1'b0, 12);
  endtask
  // Zero crossings during calibration must not move the period
  task automatic t_cal();
    int i;
    wr(`REG_MODE, 8'h03, 1'b1);
    wr(`REG_GO, 8'h01, 1'b1);
    wait_en(1'b1, 12);
    toggle(3, 30);
    for (i = 0; i < 2000 && drive_amp !== 8'h05; i++) @(negedge mclk);
    chk_byte(drive_amp, 8'h05, "ramp");
    lvl_ok = 1'b1;
    wait_en(1'b0, 200);
    lvl_ok = 1'b0;
    rd(`REG_LEVEL, 8'h05);
    rd(`REG_RES_LO, 8'h32);
    rd(`REG_STATUS, 8'h38);
    wr(`REG_LEVEL, 8'h33, 1'b1);
    rd(`REG_LEVEL, 8'h33);
  endtask
  task automatic t_edge();
    wr(`REG_TRIG, 8'h00, 1'b1);
    trig = 1'b1;
    wait_en(1'b1, 12);
    trig = 1'b0;
    tick(20);
    chk_bit(drive_en, 1'b1, "edge hold");
    trig = 1'b1;
    wait_en(1'b0, 12);
    trig = 1'b0;
    wr(`REG_TRIG, 8'h06, 1'b1);
    chk_bit(drive_ol, 1'b1, "open loop");
    trig = 1'b1;
    tick(20);
    chk_bit(drive_en, 1'b0, "pin ignored");
    trig = 1'b0;
  endtask
  task automatic t_undervoltage_lockout();
    sup_ok = 1'b0;
    rstn = 1'b0;
    tick(4);
    rstn = 1'b1;
    tick(STARTUP + 20);
    sup_ok = 1'b1;
    trig = 1'b1;
    tick(20);
    chk_bit(drive_en, 1'b0, "lockout play");
    trig = 1'b0;
    tick(PWRUP);
    rd(`REG_STATUS, 8'h31);
    wr(`REG_STATUS, 8'h01, 1'b1);
    rd(`REG_STATUS, 8'h30);
    trig = 1'b1;
    wait_en(1'b1, 12);
    trig = 1'b0;
    wait_en(1'b0, 12);
  endtask
  initial begin
    mclk = 1'b0;
    rstn = 1'b0;
    shut_n = 1'b1;
    trig = 1'b0;
    sup_ok = 1'b1;
    zc = 1'b0;
    lvl_ok = 1'b0;
    t_reset();
    t_pins();
    t_defaults();
    t_shutdown();
    t_mode_go();
    t_resonance();
    t_cal();
    t_edge();
    t_undervoltage_lockout();
    complete_run();
  end
  // Watchdog well beyond the expected run length
  initial begin
    #250us;
    miscompares++;
    $display("[ERR] %0t watchdog expired", $time);
    complete_run();
  end
endmodule // haptic_ctrl_bench
`default_nettype wire
